/* rtl/pmar_defines.vh */
// Register offsets, field positions, reset values and constants for the payload/alias registers
`ifndef PMAR_DEFINES_VH
`define PMAR_DEFINES_VH

// =====================================================================
// Register offsets
`define PMAR_OFS_MODE_SEL 8'h05
`define PMAR_OFS_DESER_ADDR 8'h06
`define PMAR_OFS_DESER_ALIAS 8'h07
`define PMAR_OFS_FAR_ADDR 8'h08
`define PMAR_OFS_FAR_ALIAS 8'h09
`define PMAR_OFS_CRC_LOW 8'h0a
`define PMAR_OFS_CRC_HIGH 8'h0b
`define PMAR_OFS_GEN_STATUS 8'h0c

// =====================================================================
// Mode select field positions
`define PMAR_BIT_OVERRIDE 5
`define PMAR_BIT_STATUS_CURRENT 4
`define PMAR_BIT_STRAP_WIDE 3
`define PMAR_BIT_STRAP_MID 2
`define PMAR_BIT_WIDE_SEL 1
`define PMAR_BIT_MID_SEL 0

// Address register hold bit and 7-bit field position
`define PMAR_BIT_HOLD 0
`define PMAR_ADDR_MSB 7
`define PMAR_ADDR_LSB 1

// General status revision field
`define PMAR_REV_MSB 7
`define PMAR_REV_LSB 5

// =====================================================================
// Reset values
`define PMAR_RST_BYTE 8'h00
`define PMAR_RST_ADDR7 7'h00
`define PMAR_RST_COUNT 16'h0000
`define PMAR_RST_MODE2 2'h0

// Silicon revision value; arbitrary neutral value
`define PMAR_SILICON_REVISION 3'h5

`endif

/* rtl/pmar_alias_map.v */
// Alias decoder: remaps a local I2C target address onto a remote address
`default_nettype none

module pmar_alias_map (
    input wire clock_i,
    input wire rst_i,
    input wire [6:0] req_addr_i,
    input wire req_valid_i,
    input wire pass_enable_i,
    input wire [6:0] alias_i,
    input wire [6:0] phys_i,
    output reg hit_o,
    output reg [6:0] remap_addr_o
);

    // =====================================================================
    // Decode match
    wire match;
    assign match = req_valid_i && pass_enable_i && (alias_i != 7'h00) &&
                   (phys_i != 7'h00) && (req_addr_i == alias_i);

    // Registered remap result, latched before crossing the control channel
    always @(posedge clock_i) begin
        if (rst_i) begin
            hit_o <= 1'b0;
            remap_addr_o <= 7'h00;
        end else begin
            hit_o <= match;
            remap_addr_o <= match ? phys_i : 7'h00;
        end
    end

endmodule
`default_nettype wire

/* rtl/pmar_crc_counter.v */
// Back-channel CRC error counter with consistent two-byte snapshot
`default_nettype none
`include "pmar_defines.vh"

module pmar_crc_counter (
    input wire clock_i,
    input wire rst_i,
    input wire crc_error_i,
    input wire snap_i,
    output reg [15:0] count_o,
    output reg [7:0] snap_high_o
);

    // =====================================================================
    // Saturating count; high byte captured when low byte is read
    always @(posedge clock_i) begin
        if (rst_i) begin
            count_o <= `PMAR_RST_COUNT;
            snap_high_o <= `PMAR_RST_BYTE;
        end else begin
            if (crc_error_i && count_o != 16'hffff) begin
                count_o <= count_o + 16'h0001;
            end
            if (snap_i) begin
                snap_high_o <= count_o[15:8];
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/pmar_regs.v */
// Payload mode and I2C alias register bank with remap outputs
`default_nettype none
`include "pmar_defines.vh"

module pmar_regs (
    input wire clock_i,
    input wire rst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Link and strap status
    input wire rx_lock_i,
    input wire bc_mode_valid_i,
    input wire [1:0] bc_mode_i,
    input wire strap_wide_i,
    input wire strap_mid_i,
    input wire bc_addr_valid_i,
    input wire [6:0] bc_addr_i,
    input wire bc_crc_error_i,
    input wire pass_enable_i,
    // Local I2C request
    input wire i2c_valid_i,
    input wire [6:0] i2c_addr_i,
    // Forwarded request across the control channel
    output reg fwd_valid_o,
    output reg [6:0] fwd_addr_o,
    // Effective transmitter payload configuration
    output reg tx_wide_payload_sel_o,
    output reg tx_mid_payload_sel_o
);

    // =====================================================================
    // Storage
    reg [2:0] mode_ctrl;
    reg [1:0] bc_mode;
    reg mode_status_current;
    reg [6:0] remote_deser_address;
    reg hold_remote_address;
    reg [7:0] remote_deser_alias;
    reg [7:0] far_target_address;
    reg [7:0] far_target_alias;
    wire [15:0] crc_count;
    wire [7:0] crc_snap_high;
    wire deser_hit;
    wire far_hit;
    wire [6:0] deser_remap;
    wire [6:0] far_remap;
    reg [7:0] next_rdata;
    reg [1:0] next_mode;
    reg [2:0] next_mode_ctrl;
    reg [1:0] next_bc_mode;
    reg next_mode_status_current;
    reg [6:0] next_remote_deser_address;
    reg next_hold_remote_address;
    reg [7:0] next_remote_deser_alias;
    reg [7:0] next_far_target_address;
    reg [7:0] next_far_target_alias;
    reg next_fwd_valid;
    reg [6:0] next_fwd_addr;
    wire wr_mode_sel;
    wire wr_deser_addr;
    wire wr_deser_alias;
    wire wr_far_addr;
    wire wr_far_alias;
    wire rd_crc_low;
    wire [6:0] map_alias [0:1];
    wire [6:0] map_phys [0:1];
    wire [1:0] map_hit;
    wire [6:0] map_remap [0:1];

    // Write decode shared by all writable registers
    function wr_hit;
        input [7:0] a;
        input [7:0] ofs;
        input w;
        begin
            wr_hit = w && (a == ofs);
        end
    endfunction

    // Per-register strobes from the shared offset decode
    assign wr_mode_sel = wr_hit(addr_i, `PMAR_OFS_MODE_SEL, wr_i);
    assign wr_deser_addr = wr_hit(addr_i, `PMAR_OFS_DESER_ADDR, wr_i);
    assign wr_deser_alias = wr_hit(addr_i, `PMAR_OFS_DESER_ALIAS, wr_i);
    assign wr_far_addr = wr_hit(addr_i, `PMAR_OFS_FAR_ADDR, wr_i);
    assign wr_far_alias = wr_hit(addr_i, `PMAR_OFS_FAR_ALIAS, wr_i);
    assign rd_crc_low = wr_hit(addr_i, `PMAR_OFS_CRC_LOW, rd_i); // Low-byte read takes snapshot

    // =====================================================================
    // Next mode control: override and the two local select bits
    always @* begin
        next_mode_ctrl = mode_ctrl;
        if (wr_mode_sel) begin
            next_mode_ctrl = {wdata_i[`PMAR_BIT_OVERRIDE],
                              wdata_i[`PMAR_BIT_WIDE_SEL], wdata_i[`PMAR_BIT_MID_SEL]};
        end
    end

    // Mode select register; read-only bits are never stored
    always @(posedge clock_i) begin
        if (rst_i) begin
            mode_ctrl <= 3'h0;
        end else begin
            mode_ctrl <= next_mode_ctrl;
        end
    end

    // Next back-channel mode; currency is lost with the lock
    always @* begin
        next_bc_mode = bc_mode;
        if (bc_mode_valid_i && rx_lock_i) begin
            next_bc_mode = bc_mode_i;
        end
        next_mode_status_current = rx_lock_i && (bc_mode_valid_i || mode_status_current);
    end

    // Back-channel mode capture and its currency flag
    always @(posedge clock_i) begin
        if (rst_i) begin
            bc_mode <= `PMAR_RST_MODE2;
            mode_status_current <= 1'b0;
        end else begin
            bc_mode <= next_bc_mode;
            mode_status_current <= next_mode_status_current;
        end
    end

    // Effective payload mode: local bits only under override
    always @* begin
        if (mode_ctrl[2]) begin
            next_mode = mode_ctrl[1:0];
        end else if (mode_status_current) begin
            next_mode = bc_mode;
        end else begin
            next_mode = {strap_wide_i, strap_mid_i};
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            tx_wide_payload_sel_o <= 1'b0;
            tx_mid_payload_sel_o <= 1'b0;
        end else begin
            tx_wide_payload_sel_o <= next_mode[1];
            tx_mid_payload_sel_o <= next_mode[0];
        end
    end

    // =====================================================================
    // Next remote address; software write wins over auto-load
    always @* begin
        next_remote_deser_address = remote_deser_address;
        next_hold_remote_address = hold_remote_address;
        if (wr_deser_addr) begin
            next_remote_deser_address = wdata_i[`PMAR_ADDR_MSB:`PMAR_ADDR_LSB];
            next_hold_remote_address = wdata_i[`PMAR_BIT_HOLD];
        end else if (rx_lock_i && bc_addr_valid_i && !hold_remote_address) begin
            next_remote_deser_address = bc_addr_i;
        end
    end

    // Remote deserializer address and hold flops
    always @(posedge clock_i) begin
        if (rst_i) begin
            remote_deser_address <= `PMAR_RST_ADDR7;
            hold_remote_address <= 1'b0;
        end else begin
            remote_deser_address <= next_remote_deser_address;
            hold_remote_address <= next_hold_remote_address;
        end
    end

    // Next alias and far-target values
    always @* begin
        next_remote_deser_alias = wr_deser_alias ? wdata_i : remote_deser_alias;
        next_far_target_address = wr_far_addr ? wdata_i : far_target_address;
        next_far_target_alias = wr_far_alias ? wdata_i : far_target_alias;
    end

    // Alias and far-target registers
    always @(posedge clock_i) begin
        if (rst_i) begin
            remote_deser_alias <= `PMAR_RST_BYTE;
            far_target_address <= `PMAR_RST_BYTE;
            far_target_alias <= `PMAR_RST_BYTE;
        end else begin
            remote_deser_alias <= next_remote_deser_alias;
            far_target_address <= next_far_target_address;
            far_target_alias <= next_far_target_alias;
        end
    end

    // =====================================================================
    // Alias decoders
    // Decoder slot 0 serves the deserializer alias, slot 1 the far target
    assign map_alias[0] = remote_deser_alias[7:1];
    assign map_phys[0] = remote_deser_address;
    assign map_alias[1] = far_target_alias[7:1];
    assign map_phys[1] = far_target_address[7:1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_map
            pmar_alias_map u_map (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .req_addr_i(i2c_addr_i),
                .req_valid_i(i2c_valid_i),
                .pass_enable_i(pass_enable_i),
                .alias_i(map_alias[gi]),
                .phys_i(map_phys[gi]),
                .hit_o(map_hit[gi]),
                .remap_addr_o(map_remap[gi])
            );
        end
    endgenerate

    // Decoder results by slot
    assign deser_hit = map_hit[0];
    assign far_hit = map_hit[1];
    assign deser_remap = map_remap[0];
    assign far_remap = map_remap[1];

    // Deserializer alias wins when both decoders hit
    always @* begin
        next_fwd_valid = deser_hit || far_hit;
        if (deser_hit) begin
            next_fwd_addr = deser_remap;
        end else begin
            next_fwd_addr = far_remap;
        end
    end

    // Forwarded address is already remapped when it leaves toward the link
    always @(posedge clock_i) begin
        if (rst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_addr_o <= 7'h00;
        end else begin
            fwd_valid_o <= next_fwd_valid;
            fwd_addr_o <= next_fwd_addr;
        end
    end

    // =====================================================================
    // CRC error counter
    pmar_crc_counter u_crc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .crc_error_i(bc_crc_error_i),
        .snap_i(rd_crc_low),
        .count_o(crc_count),
        .snap_high_o(crc_snap_high)
    );

    // =====================================================================
    // Read mux
    always @* begin
        case (addr_i)
            `PMAR_OFS_MODE_SEL: next_rdata = {2'h0, mode_ctrl[2], mode_status_current,
                                              strap_wide_i, strap_mid_i,
                                              mode_ctrl[1:0]};
            `PMAR_OFS_DESER_ADDR: next_rdata = {remote_deser_address, hold_remote_address};
            `PMAR_OFS_DESER_ALIAS: next_rdata = remote_deser_alias;
            `PMAR_OFS_FAR_ADDR: next_rdata = far_target_address;
            `PMAR_OFS_FAR_ALIAS: next_rdata = far_target_alias;
            `PMAR_OFS_CRC_LOW: next_rdata = crc_count[7:0];
            `PMAR_OFS_CRC_HIGH: next_rdata = crc_snap_high;
            `PMAR_OFS_GEN_STATUS: next_rdata = {`PMAR_SILICON_REVISION, 5'h00};
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

endmodule
`default_nettype wire

/* verification/pmar_deser_model.sv */
// Remote deserializer model on the far side of the control channel
`default_nettype none
module pmar_deser_model (
    input wire logic clock_i,
    input wire logic fwd_valid_i,
    input wire logic [6:0] fwd_addr_i,
    output var logic rx_lock_o,
    output var logic mode_valid_o,
    output var logic [1:0] mode_o,
    output var logic addr_valid_o,
    output var logic [6:0] addr_o,
    output var logic crc_error_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] fwd_q[$];
    // ==========
    // Quiet lines at time zero
    initial begin
        {rx_lock_o, mode_valid_o, mode_o, addr_valid_o, addr_o, crc_error_o} = 13'h0;
    end
    // Collect every request that crossed the channel
    always @(posedge clock_i) begin
        if (fwd_valid_i === 1'b1) fwd_q.push_back(fwd_addr_i);
    end
    // Lock level of the link
    task automatic lock(input logic l);
        @(posedge clock_i) rx_lock_o <= l;
    endtask
    // One-cycle delivery; released lines then show the inverse value
    task automatic send(input logic is_mode, input logic [6:0] v);
        @(posedge clock_i);
        if (is_mode) {mode_o, mode_valid_o} <= {v[1:0], 1'b1};
        else {addr_o, addr_valid_o} <= {v, 1'b1};
        @(posedge clock_i);
        {mode_o, mode_valid_o, addr_o, addr_valid_o} <= {~mode_o, 1'b0, ~addr_o, 1'b0};
    endtask
    // Back-to-back error pulses, one per cycle
    task automatic crc(input int n);
        @(posedge clock_i) crc_error_o <= 1'b1;
        repeat (n) @(posedge clock_i);
        crc_error_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/pmar_regs_sva.sv */
// Port checker for the payload mode and alias register bank
`default_nettype none
`include "pmar_defines.vh"
module pmar_regs_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic strap_wide_i,
    input wire logic strap_mid_i,
    input wire logic pass_enable_i,
    input wire logic i2c_valid_i,
    input wire logic fwd_valid_o,
    input wire logic [6:0] fwd_addr_o,
    input wire logic tx_wide_payload_sel_o,
    input wire logic tx_mid_payload_sel_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // ==========
    // Write of the mode byte with override set
    sequence s_ovr_wr;
        wr_i && addr_i == `PMAR_OFS_MODE_SEL && wdata_i[5];
    endsequence
    property p_ovr;
        s_ovr_wr |-> ##2 tx_wide_payload_sel_o == $past(wdata_i[1], 2)
            && tx_mid_payload_sel_o == $past(wdata_i[0], 2);
    endproperty
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    property p_unmapped;
        rd_i && (addr_i < 8'h05 || addr_i > 8'h0c) |=> rdata_o == 8'h00;
    endproperty
    property p_mode_rd;
        rd_i && addr_i == `PMAR_OFS_MODE_SEL |=> rdata_o[7:6] == 2'h0
            && rdata_o[3:2] == {$past(strap_wide_i), $past(strap_mid_i)};
    endproperty
    property p_rev;
        rd_i && addr_i == `PMAR_OFS_GEN_STATUS |=> rdata_o[7:5] == `PMAR_SILICON_REVISION;
    endproperty
    property p_fwd_src;
        fwd_valid_o |-> $past(i2c_valid_i, 2);
    endproperty
    property p_fwd_nz;
        fwd_valid_o |-> fwd_addr_o != 7'h00;
    endproperty
    property p_fwd_pass;
        fwd_valid_o |-> $past(pass_enable_i, 2);
    endproperty
    a_ovr: assert property (p_ovr) else $error("override mode not applied");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_mode_rd: assert property (p_mode_rd) else $error("strap bits wrong");
    a_rev: assert property (p_rev) else $error("revision field wrong");
    a_fwd_src: assert property (p_fwd_src) else $error("forward without request");
    a_fwd_nz: assert property (p_fwd_nz) else $error("forward to zero address");
    a_fwd_pass: assert property (p_fwd_pass) else $error("forward while disabled");
endmodule
bind pmar_regs pmar_regs_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .strap_wide_i(strap_wide_i), .strap_mid_i(strap_mid_i), .pass_enable_i(pass_enable_i),
    .i2c_valid_i(i2c_valid_i), .fwd_valid_o(fwd_valid_o), .fwd_addr_o(fwd_addr_o),
    .tx_wide_payload_sel_o(tx_wide_payload_sel_o), .tx_mid_payload_sel_o(tx_mid_payload_sel_o));
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the payload mode and alias register bank
`default_nettype none
`include "pmar_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 0;
    logic rst_i = 1;
    logic we = 0, re = 0, sw = 0, sm = 0, pass = 0, iv = 0, cur = 0;
    logic [7:0] ad = 0, wd = 0;
    logic [6:0] ia = 0, v, da, fp;
    logic [1:0] bcm = 0;
    logic [31:0] seed = 32'h4d;
    logic [7:0] r [0:15] = '{default: 8'h00};
    int cnt = 0, bad_count = 0, samples_checked = 0;
    wire logic lk, mv, av, ce, fv, tw, tm;
    wire logic [1:0] bm;
    wire logic [6:0] ba, fa;
    wire logic [7:0] rdat;
    // ==========
    // Clock, design and far-side model
    always #25 clock_i = ~clock_i;
    pmar_regs dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(ad), .wdata_i(wd), .wr_i(we),
        .rd_i(re), .rdata_o(rdat), .rx_lock_i(lk), .bc_mode_valid_i(mv), .bc_mode_i(bm),
        .strap_wide_i(sw), .strap_mid_i(sm), .bc_addr_valid_i(av), .bc_addr_i(ba),
        .bc_crc_error_i(ce), .pass_enable_i(pass), .i2c_valid_i(iv), .i2c_addr_i(ia),
        .fwd_valid_o(fv), .fwd_addr_o(fa), .tx_wide_payload_sel_o(tw),
        .tx_mid_payload_sel_o(tm));
    pmar_deser_model dm (.clock_i(clock_i), .fwd_valid_i(fv), .fwd_addr_i(fa),
        .rx_lock_o(lk), .mode_valid_o(mv), .mode_o(bm), .addr_valid_o(av), .addr_o(ba),
        .crc_error_o(ce));
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected read value of each offset
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h05: return {2'h0, r[5][5], cur, sw, sm, r[5][1:0]};
            8'h06, 8'h07, 8'h08, 8'h09: return r[a[3:0]];
            8'h0a: return cnt[7:0];
            8'h0b: return cnt[15:8];
            8'h0c: return {`PMAR_SILICON_REVISION, 5'h00};
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Register port cycles; the model follows each write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        ad <= a;
        wd <= d;
        we <= 1;
        @(posedge clock_i);
        we <= 0;
        r[a[3:0]] = (a == 8'h05) ? d & 8'h23 : d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        ad <= a;
        re <= 1;
        @(posedge clock_i);
        re <= 0;
        @(negedge clock_i);
        chk(rdat, exp_rd(a));
    endtask
    task automatic txc();
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk({tw, tm}, r[5][5] ? r[5][1:0] : (cur ? bcm : {sw, sm}));
    endtask
    // Local request; e is the expected forwarded address, zero for none
    task automatic go(input logic [6:0] a, input logic [6:0] e);
        @(posedge clock_i);
        ia <= a;
        iv <= 1;
        @(posedge clock_i);
        iv <= 0;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk(16'(dm.fwd_q.size()), e != 0);
        if (e != 0) chk(dm.fwd_q.pop_front(), e);
    endtask
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 0;
        for (int a = 4; a < 16; a++) rd(a[7:0]);
        $display("Reset test done");
        @(posedge clock_i) {sw, sm} <= 2'h1;
        rd(8'h05);
        txc();
        wr(8'h05, 8'(rnd()) & 8'hdc | 8'h22);
        rd(8'h05);
        txc();
        wr(8'h05, 8'h02);
        txc();
        dm.lock(1);
        dm.send(1, 7'h02);
        cur = 1;
        bcm = 2'h2;
        rd(8'h05);
        txc();
        dm.lock(0);
        cur = 0;
        rd(8'h05);
        txc();
        @(posedge clock_i) {sw, sm} <= 2'h2;
        rd(8'h05);
        txc();
        wr(8'h05, 8'h21);
        txc();
        wr(8'h05, 8'h01);
        txc();
        $display("Mode test done");
        dm.lock(1);
        v = 7'(rnd()) | 7'h01;
        dm.send(0, v);
        r[6] = {v, 1'b0};
        rd(8'h06);
        wr(8'h06, 8'(rnd()) | 8'h03);
        dm.send(0, ~r[6][7:1]);
        rd(8'h06);
        $display("Address test done");
        @(posedge clock_i) pass <= 1;
        da = 7'(rnd()) & 7'h3f | 7'h01;
        fp = 7'(rnd()) | 7'h01;
        wr(8'h07, {da, 1'b0});
        wr(8'h08, {fp, 1'b0});
        wr(8'h09, {da | 7'h40, 1'b0});
        go(da, r[6][7:1]);
        go(da | 7'h40, fp);
        go(da ^ 7'h20, 7'h00);
        @(posedge clock_i) pass <= 0;
        go(da, 7'h00);
        @(posedge clock_i) pass <= 1;
        wr(8'h08, 8'h00);
        go(da | 7'h40, 7'h00);
        wr(8'h06, 8'h01);
        go(da, 7'h00);
        wr(8'h07, 8'h00);
        go(7'h00, 7'h00);
        $display("Alias test done");
        cnt = 256 + int'(rnd() % 64);
        dm.crc(cnt);
        rd(8'h0a);
        rd(8'h0b);
        dm.crc(1);
        cnt++;
        rd(8'h0a);
        rd(8'h0b);
        // Errors after the low-byte read must not reach the high byte read
        rd(8'h0a);
        dm.crc(256);
        rd(8'h0b);
        cnt += 256;
        rd(8'h0a);
        rd(8'h0b);
        $display("Counter test done");
        conclude();
    end
endmodule
`default_nettype wire
